//--- rv_cfg.svh
// Register offsets, field positions, reset values and timing for ring validation
`ifndef RV_CFG_SVH
`define RV_CFG_SVH

`define RV_OFS_RING_CONFIRM 8'h00
`define RV_OFS_RING_MIN_FREQ 8'h04
`define RV_OFS_RING_TMO_MAX 8'h08
`define RV_OFS_LINE_HOOK 8'h0c
`define RV_OFS_IRQ_STATUS 8'h10
`define RV_OFS_IRQ_MASK 8'h14
`define RV_OFS_RING_STATE 8'h18

`define RV_RST_RING_CONFIRM 8'h88
`define RV_RST_RING_MIN_FREQ 8'h19
`define RV_RST_RING_TMO_MAX 8'h16
`define RV_RST_LINE_HOOK 8'h40

`define RV_MASK_RING_CONFIRM 8'hfe
`define RV_MASK_RING_MIN_FREQ 8'h3f
`define RV_MASK_RING_TMO_MAX 8'hff
`define RV_MASK_LINE_HOOK 8'hc3

`define RV_BIT_ENABLE 7
`define RV_POS_DELAY 4
`define RV_POS_CONFIRM 1
`define RV_POS_TIMEOUT 4
`define RV_POS_MAXCNT 0
`define RV_POS_FASTOFF 6
`define RV_POS_MODE 0

`define RV_ST_RING_VALID 0
`define RV_ST_TOO_SLOW 1
`define RV_ST_TOO_FAST 2
`define RV_ST_RING_OVER 3
`define RV_ST_OFFHOOK 4

`define RV_MODE_ONHOOK 2'h0
`define RV_MODE_OFFHOOK 2'h1
`define RV_MODE_MONITOR 2'h2
`define RV_MODE_RESERVED 2'h3

`define RV_CLK_PERIOD_NS 8
`define RV_TICK_MS 2
`define RV_TICK_PERIOD_NS (`RV_TICK_MS * 1000000)
`define RV_TICK_CYCLES (`RV_TICK_PERIOD_NS / `RV_CLK_PERIOD_NS)

`define RV_TMO_FIRST_MS 80
`define RV_TMO_STEP_MS 128
`define RV_DELAY_STEP_MS 256
`define RV_CONF0_MS 100
`define RV_CONF1_MS 150
`define RV_CONF2_MS 200
`define RV_CONF3_MS 256
`define RV_CONF4_MS 384
`define RV_CONF5_MS 512
`define RV_CONF6_MS 640
`define RV_CONF7_MS 1024
`define RV_FASTOFF0_MS 512
`define RV_FASTOFF1_MS 128
`define RV_FASTOFF2_MS 64
`define RV_FASTOFF3_MS 8

`endif

//--- rv_pkg.sv
// Types shared by the ring validation block
package rv_pkg;

	typedef enum logic [1:0] {
		RV_IDLE = 2'b00,
		RV_QUAL = 2'b01,
		RV_DELAY = 2'b10,
		RV_VALID = 2'b11
	} rv_state_t;

	typedef struct packed {
		logic [17:0] count;
		logic tick;
	} rv_tick_regs_t;

	typedef struct packed {
		logic [1:0] sync;
		logic evt_d;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [7:0] ring_confirm;
		logic [7:0] ring_min_freq;
		logic [7:0] ring_tmo_max;
		logic [7:0] line_hook;
		logic [4:0] status;
		logic [4:0] mask;
		logic irq;
		rv_state_t state;
		logic [5:0] qtimer;
		logic [9:0] cnt;
		logic [9:0] since;
		logic ring_valid;
		logic [9:0] offhook_cnt;
		logic offhook_ok;
	} rv_regs_t;

endpackage

//--- rv_tick.sv
// Divider that pulses once per qualification time unit
`timescale 1ns/100ps
module rv_tick #(
	parameter int DIV = 250000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Tick output
	output logic tick
);

	rv_pkg::rv_tick_regs_t r;
	rv_pkg::rv_tick_regs_t next_r;

	always_comb
	begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.count == 18'(DIV - 1))
		begin
			next_r.count = 18'h00000;
			next_r.tick = 1'b1;
		end
		else
		begin
			next_r.count = r.count + 18'h00001;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick = r.tick;

endmodule

//--- rv_top.sv
// Ring qualification, ring timeout, fast off-hook counter and line mode behind an AHB-Lite slave
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "rv_cfg.svh"

module rv_top #(
	parameter int TICK_CYCLES = `RV_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Line side
	input wire logic ring_thresh,
	output logic [1:0] line_mode_sel,
	output logic offhook_done,
	// Internal controller line mode update
	input wire logic ctrl_mode_load,
	input wire logic [1:0] ctrl_mode,
	// Ring indication and interrupt
	output logic ring_valid,
	output logic irq
);

	rv_pkg::rv_regs_t r;
	rv_pkg::rv_regs_t next_r;
	logic tick;
	logic ev;
	logic [4:0] set_st;
	logic [4:0] clr_st;
	logic [9:0] tmo_ticks;
	logic [9:0] conf_ticks;
	logic [9:0] dly_ticks;
	logic [9:0] offhook_len;
	logic ap;

	rv_tick #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);

	function automatic logic [9:0] ms_ticks(input int ms);
		ms_ticks = 10'(ms / `RV_TICK_MS);
	endfunction

	function automatic logic [9:0] timeout_ticks(input logic [3:0] code);
		if (code == 4'h0)
			timeout_ticks = ms_ticks(`RV_TMO_FIRST_MS);
		else
			timeout_ticks = 10'(int'(code) * `RV_TMO_STEP_MS / `RV_TICK_MS);
	endfunction

	function automatic logic [9:0] confirm_ticks(input logic [2:0] code);
		case (code)
			3'h0: confirm_ticks = ms_ticks(`RV_CONF0_MS);
			3'h1: confirm_ticks = ms_ticks(`RV_CONF1_MS);
			3'h2: confirm_ticks = ms_ticks(`RV_CONF2_MS);
			3'h3: confirm_ticks = ms_ticks(`RV_CONF3_MS);
			3'h4: confirm_ticks = ms_ticks(`RV_CONF4_MS);
			3'h5: confirm_ticks = ms_ticks(`RV_CONF5_MS);
			3'h6: confirm_ticks = ms_ticks(`RV_CONF6_MS);
			default: confirm_ticks = ms_ticks(`RV_CONF7_MS);
		endcase
	endfunction

	function automatic logic [9:0] offhook_ticks(input logic [1:0] code);
		case (code)
			2'h0: offhook_ticks = ms_ticks(`RV_FASTOFF0_MS);
			2'h1: offhook_ticks = ms_ticks(`RV_FASTOFF1_MS);
			2'h2: offhook_ticks = ms_ticks(`RV_FASTOFF2_MS);
			default: offhook_ticks = ms_ticks(`RV_FASTOFF3_MS);
		endcase
	endfunction

	function automatic logic [31:0] read_mux(input rv_pkg::rv_regs_t s, input logic [7:0] a);
		case (a)
			`RV_OFS_RING_CONFIRM: read_mux = {24'h000000, s.ring_confirm};
			`RV_OFS_RING_MIN_FREQ: read_mux = {24'h000000, s.ring_min_freq};
			`RV_OFS_RING_TMO_MAX: read_mux = {24'h000000, s.ring_tmo_max};
			`RV_OFS_LINE_HOOK: read_mux = {24'h000000, s.line_hook};
			`RV_OFS_IRQ_STATUS: read_mux = {27'h0000000, s.status};
			`RV_OFS_IRQ_MASK: read_mux = {27'h0000000, s.mask};
			`RV_OFS_RING_STATE: read_mux = {20'h00000, s.line_hook[1:0], s.offhook_ok, s.ring_valid,
				s.state, s.qtimer};
			default: read_mux = 32'h00000000;
		endcase
	endfunction

	// Times in 2 ms ticks
	assign tmo_ticks = timeout_ticks(r.ring_tmo_max[`RV_POS_TIMEOUT +: 4]);
	assign conf_ticks = confirm_ticks(r.ring_confirm[`RV_POS_CONFIRM +: 3]);
	assign dly_ticks = 10'(int'(r.ring_confirm[`RV_POS_DELAY +: 3]) * `RV_DELAY_STEP_MS / `RV_TICK_MS);
	assign offhook_len = offhook_ticks(r.line_hook[`RV_POS_FASTOFF +: 2]);
	// Rising edge of the synchronised threshold input
	assign ev = r.sync[1] & ~r.evt_d;
	assign ap = hsel & hready & htrans[1];

	always_comb
	begin
		next_r = r;
		set_st = 5'h00;
		clr_st = 5'h00;
		next_r.sync = {r.sync[0], ring_thresh};
		next_r.evt_d = r.sync[1];

		// Bus address phase: capture, read data, clear status on read
		next_r.ap_valid = ap;
		next_r.ap_write = hwrite;
		next_r.ap_addr = {haddr[7:2], 2'b00};
		next_r.hreadyout = 1'b1;
		if (ap && !hwrite)
		begin
			next_r.hrdata = read_mux(r, {haddr[7:2], 2'b00});
			if ({haddr[7:2], 2'b00} == `RV_OFS_IRQ_STATUS)
				clr_st = 5'h1f;
		end

		// Bus data phase write
		if (r.ap_valid && r.ap_write)
		begin
			case (r.ap_addr)
				`RV_OFS_RING_CONFIRM: next_r.ring_confirm = hwdata[7:0] & `RV_MASK_RING_CONFIRM;
				`RV_OFS_RING_MIN_FREQ: next_r.ring_min_freq = hwdata[7:0] & `RV_MASK_RING_MIN_FREQ;
				`RV_OFS_RING_TMO_MAX: next_r.ring_tmo_max = hwdata[7:0] & `RV_MASK_RING_TMO_MAX;
				`RV_OFS_LINE_HOOK:
				begin
					next_r.line_hook[`RV_POS_FASTOFF +: 2] = hwdata[`RV_POS_FASTOFF +: 2];
					if (hwdata[1:0] != `RV_MODE_RESERVED)
						next_r.line_hook[`RV_POS_MODE +: 2] = hwdata[1:0];
				end
				`RV_OFS_IRQ_MASK: next_r.mask = hwdata[4:0];
				default:
				begin
				end
			endcase
		end

		// Internal controller owns the line mode and wins over a bus write
		if (ctrl_mode_load && ctrl_mode != `RV_MODE_RESERVED)
			next_r.line_hook[`RV_POS_MODE +: 2] = ctrl_mode;

		// Ring qualification
		if (!r.ring_confirm[`RV_BIT_ENABLE])
		begin
			next_r.state = rv_pkg::RV_IDLE;
			next_r.ring_valid = 1'b0;
			next_r.cnt = 10'h000;
			next_r.since = 10'h000;
			next_r.qtimer = 6'h00;
		end
		else
		begin
			if (tick && r.qtimer != 6'h00)
				next_r.qtimer = r.qtimer - 6'h01;
			if (tick && r.since != 10'h3ff)
				next_r.since = r.since + 10'h001;
			if (tick && r.cnt != 10'h3ff)
				next_r.cnt = r.cnt + 10'h001;
			case (r.state)
				rv_pkg::RV_IDLE:
				begin
					next_r.cnt = 10'h000;
				end
				rv_pkg::RV_QUAL:
				begin
					if (r.cnt >= conf_ticks)
					begin
						next_r.cnt = 10'h000;
						if (dly_ticks == 10'h000)
						begin
							next_r.state = rv_pkg::RV_VALID;
							next_r.ring_valid = 1'b1;
							set_st[`RV_ST_RING_VALID] = 1'b1;
						end
						else
							next_r.state = rv_pkg::RV_DELAY;
					end
				end
				rv_pkg::RV_DELAY:
				begin
					if (r.cnt >= dly_ticks)
					begin
						next_r.state = rv_pkg::RV_VALID;
						next_r.ring_valid = 1'b1;
						set_st[`RV_ST_RING_VALID] = 1'b1;
					end
				end
				rv_pkg::RV_VALID:
				begin
					next_r.cnt = 10'h000;
				end
				default:
				begin
					next_r.state = rv_pkg::RV_IDLE;
				end
			endcase
			if (ev)
			begin
				// Timer units are the 2 ms ticks
				next_r.qtimer = r.ring_min_freq[5:0];
				next_r.since = 10'h000;
				if (r.state == rv_pkg::RV_IDLE)
				begin
					next_r.state = rv_pkg::RV_QUAL;
					next_r.cnt = 10'h000;
				end
				else if (r.qtimer == 6'h00)
				begin
					set_st[`RV_ST_TOO_SLOW] = 1'b1;
					next_r.state = rv_pkg::RV_QUAL;
					next_r.cnt = 10'h000;
					next_r.ring_valid = 1'b0;
				end
				else if (r.qtimer > {2'b00, r.ring_tmo_max[`RV_POS_MAXCNT +: 4]})
				begin
					set_st[`RV_ST_TOO_FAST] = 1'b1;
					next_r.state = rv_pkg::RV_QUAL;
					next_r.cnt = 10'h000;
					next_r.ring_valid = 1'b0;
				end
			end
			else if (r.state != rv_pkg::RV_IDLE && r.since >= tmo_ticks)
			begin
				set_st[`RV_ST_RING_OVER] = 1'b1;
				next_r.state = rv_pkg::RV_IDLE;
				next_r.ring_valid = 1'b0;
				next_r.cnt = 10'h000;
			end
		end

		// Fast off-hook counter runs from the moment the line goes off-hook
		if (r.line_hook[`RV_POS_MODE +: 2] != `RV_MODE_OFFHOOK)
		begin
			next_r.offhook_cnt = offhook_len;
			next_r.offhook_ok = 1'b0;
		end
		else if (r.offhook_cnt != 10'h000)
		begin
			if (tick)
				next_r.offhook_cnt = r.offhook_cnt - 10'h001;
		end
		else if (!r.offhook_ok)
		begin
			next_r.offhook_ok = 1'b1;
			set_st[`RV_ST_OFFHOOK] = 1'b1;
		end

		// Sticky status: a set in the clearing cycle survives
		next_r.status = (r.status & ~clr_st) | set_st;
		next_r.irq = |(next_r.status & next_r.mask);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.hreadyout <= 1'b1;
			r.ring_confirm <= `RV_RST_RING_CONFIRM;
			r.ring_min_freq <= `RV_RST_RING_MIN_FREQ;
			r.ring_tmo_max <= `RV_RST_RING_TMO_MAX;
			r.line_hook <= `RV_RST_LINE_HOOK;
			r.state <= rv_pkg::RV_IDLE;
		end
		else
			r <= next_r;
	end

	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = 1'b0;
	assign line_mode_sel = r.line_hook[`RV_POS_MODE +: 2];
	assign offhook_done = r.offhook_ok;
	assign ring_valid = r.ring_valid;
	assign irq = r.irq;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_busy_event;
		ev && r.ring_confirm[`RV_BIT_ENABLE] && r.state != rv_pkg::RV_IDLE;
	endsequence

	sequence s_back_to_qual;
		r.state == rv_pkg::RV_QUAL && r.cnt == 10'h000 && !r.ring_valid;
	endsequence

	a_timer_load: assert property (ev && r.ring_confirm[`RV_BIT_ENABLE] |=> r.qtimer == $past(r.ring_min_freq[5:0]))
		else $error("qualification timer not loaded on event");
	a_too_slow: assert property (s_busy_event and r.qtimer == 6'h00 |=> s_back_to_qual and r.status[`RV_ST_TOO_SLOW])
		else $error("slow ring not invalidated");
	a_too_fast: assert property (s_busy_event and r.qtimer != 6'h00
		and r.qtimer > {2'b00, r.ring_tmo_max[3:0]} |=> s_back_to_qual and r.status[`RV_ST_TOO_FAST])
		else $error("fast ring not invalidated");
	a_timer_step: assert property (tick && !ev && r.ring_confirm[`RV_BIT_ENABLE] && r.qtimer != 6'h00
		|=> r.qtimer == $past(r.qtimer) - 6'h01)
		else $error("qualification timer did not step");
	a_timer_hold: assert property (!tick && !ev && r.ring_confirm[`RV_BIT_ENABLE] |=> $stable(r.qtimer))
		else $error("qualification timer moved between ticks");
	a_ring_over: assert property (!ev && r.state != rv_pkg::RV_IDLE && r.since >= tmo_ticks
		&& r.ring_confirm[`RV_BIT_ENABLE] |=> r.state == rv_pkg::RV_IDLE && !ring_valid)
		else $error("ring not ended at timeout");
	a_offhook_len: assert property (r.line_hook[1:0] != `RV_MODE_OFFHOOK
		|=> r.offhook_cnt == $past(offhook_len) && !offhook_done)
		else $error("off-hook counter length wrong");
	a_mode_legal: assert property (line_mode_sel != `RV_MODE_RESERVED)
		else $error("reserved line mode selected");
	a_ctrl_mode: assert property (ctrl_mode_load && ctrl_mode != `RV_MODE_RESERVED
		|=> line_mode_sel == $past(ctrl_mode))
		else $error("controller line mode not applied");
	a_disabled_idle: assert property (!r.ring_confirm[`RV_BIT_ENABLE] |=> r.state == rv_pkg::RV_IDLE ##1 !ring_valid)
		else $error("qualification active while disabled");
	a_confirm_time: assert property ($rose(r.state == rv_pkg::RV_DELAY || r.state == rv_pkg::RV_VALID)
		&& $past(r.state) == rv_pkg::RV_QUAL |-> $past(r.cnt) >= $past(conf_ticks))
		else $error("ring confirmed too early");
	a_delay_time: assert property ($rose(ring_valid)
		|-> $past(r.state) == rv_pkg::RV_QUAL && $past(dly_ticks) == 10'h000 || $past(r.cnt) >= $past(dly_ticks))
		else $error("ring indicated before delay");
	a_reserved_zero: assert property (r.ring_min_freq[7:6] == 2'b00 && r.line_hook[5:2] == 4'h0
		&& !r.ring_confirm[0])
		else $error("reserved bits not zero");

endmodule

//--- rv_line_model.sv
// Telephone line model that produces ring threshold events
`timescale 1ns/100ps
module rv_line_model #(
	parameter int TC = 20
) (
	// Clock
	input wire logic clk,
	// Line threshold event
	output logic ring_thresh
);
	initial ring_thresh = 1'b0;
	// Events n times, gap ticks apart; high 3 cycles so the synchroniser sees each one
	task automatic ring(input int n, input int gap);
		repeat (n)
		begin
			@(posedge clk);
			ring_thresh <= 1'b1;
			repeat (3) @(posedge clk);
			ring_thresh <= 1'b0;
			repeat (gap * TC - 4) @(posedge clk);
		end
	endtask
endmodule

//--- rv_top_tb_top.sv
// Self-checking bench for the ring validation block
`timescale 1ns/100ps
`include "rv_cfg.svh"
module rv_top_tb_top;
	localparam int TC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic ctrl_mode_load = 1'b0;
	logic [1:0] ctrl_mode = 2'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic ring_thresh;
	logic offhook_done;
	logic ring_valid;
	logic irq;
	logic [1:0] line_mode_sel;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int offhook_len_ticks [4] = '{256, 64, 32, 4};

	always #4 clk = ~clk;

	rv_top #(.TICK_CYCLES(TC)) rv_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ring_thresh(ring_thresh), .line_mode_sel(line_mode_sel),
		.offhook_done(offhook_done), .ctrl_mode_load(ctrl_mode_load), .ctrl_mode(ctrl_mode),
		.ring_valid(ring_valid), .irq(irq));
	rv_line_model #(.TC(TC)) rv_line_model_i (.clk(clk), .ring_thresh(ring_thresh));

	task automatic summarize;
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n * TC) @(posedge clk);
	endtask

	// Address phase held until hready, then bus goes idle for the data phase
	task automatic aph(input logic [7:0] a, input logic w);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		aph(a, 1'b1);
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		aph(a, 1'b0);
		do @(posedge clk); while (hreadyout !== 1'b1);
		chk(hrdata, e);
		chk(hresp, 32'h0);
	endtask

	// Internal controller sets the line mode
	task automatic set_mode(input logic [1:0] v);
		@(posedge clk);
		ctrl_mode_load <= 1'b1;
		ctrl_mode <= v;
		@(posedge clk);
		ctrl_mode_load <= 1'b0;
		@(posedge clk);
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			summarize();
		end
	end

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(`RV_OFS_RING_CONFIRM, 32'h88);
		rdc(`RV_OFS_RING_MIN_FREQ, 32'h19);
		rdc(`RV_OFS_RING_TMO_MAX, 32'h16);
		rdc(`RV_OFS_LINE_HOOK, 32'h40);
		rdc(`RV_OFS_IRQ_STATUS, 32'h0);
		rdc(`RV_OFS_IRQ_MASK, 32'h0);
		rdc(8'h1c, 32'h0);
		wr(`RV_OFS_RING_MIN_FREQ, 8'hff);
		rdc(`RV_OFS_RING_MIN_FREQ, 32'h3f);
		wr(`RV_OFS_RING_CONFIRM, 8'hff);
		rdc(`RV_OFS_RING_CONFIRM, 32'hfe);
		wr(`RV_OFS_LINE_HOOK, 8'h02);
		@(posedge clk);
		chk(line_mode_sel, 2'h2);
		wr(`RV_OFS_LINE_HOOK, 8'hff);
		rdc(`RV_OFS_LINE_HOOK, 32'hc2);
		// About 41.7 Hz lowest ring frequency (12 ticks, 24 ms), max count 4, timeout 80 ms
		wr(`RV_OFS_RING_MIN_FREQ, 8'h0c);
		wr(`RV_OFS_RING_TMO_MAX, 8'h04);
		wr(`RV_OFS_IRQ_MASK, 8'h1f);
		wr(`RV_OFS_RING_CONFIRM, 8'h80);
		// Events 2 ticks apart leave 10 on the timer
		rv_line_model_i.ring(2, 2);
		chk(irq, 1'b1);
		rdc(`RV_OFS_IRQ_STATUS, 32'h04);
		@(posedge clk);
		chk(irq, 1'b0);
		wt(34);
		rdc(`RV_OFS_IRQ_STATUS, 32'h0);
		wt(6);
		rdc(`RV_OFS_IRQ_STATUS, 32'h08);
		// Events 14 ticks apart find the timer expired; masked off from irq
		wr(`RV_OFS_IRQ_MASK, 8'h04);
		rv_line_model_i.ring(2, 14);
		chk(irq, 1'b0);
		rdc(`RV_OFS_IRQ_STATUS, 32'h02);
		wt(30);
		rdc(`RV_OFS_IRQ_STATUS, 32'h08);
		// Good ring: confirm 50 ticks, then delay 128 ticks before indication
		wr(`RV_OFS_IRQ_MASK, 8'h01);
		wr(`RV_OFS_RING_CONFIRM, 8'h90);
		rv_line_model_i.ring(15, 10);
		chk(ring_valid, 1'b0);
		rv_line_model_i.ring(5, 10);
		chk(ring_valid, 1'b1);
		chk(irq, 1'b1);
		rdc(`RV_OFS_IRQ_STATUS, 32'h01);
		wt(40);
		chk(ring_valid, 1'b0);
		rdc(`RV_OFS_IRQ_STATUS, 32'h08);
		// Delay 0 indicates at confirmation; timeout code 1 outlasts code 0
		wr(`RV_OFS_RING_TMO_MAX, 8'h14);
		wr(`RV_OFS_RING_CONFIRM, 8'h80);
		rv_line_model_i.ring(7, 10);
		chk(ring_valid, 1'b1);
		rdc(`RV_OFS_IRQ_STATUS, 32'h01);
		wt(45);
		chk(ring_valid, 1'b1);
		wt(15);
		chk(ring_valid, 1'b0);
		rdc(`RV_OFS_IRQ_STATUS, 32'h08);
		// Disabled qualification ignores slow events
		wr(`RV_OFS_RING_CONFIRM, 8'h00);
		rv_line_model_i.ring(3, 14);
		rdc(`RV_OFS_IRQ_STATUS, 32'h0);
		chk(ring_valid, 1'b0);
		// Off-hook counter length for each fast off-hook code
		for (int i = 0; i < 4; i++)
		begin
			set_mode(2'h0);
			wr(`RV_OFS_LINE_HOOK, {i[1:0], 6'h0});
			set_mode(2'h1);
			chk(line_mode_sel, 2'h1);
			wt(offhook_len_ticks[i] - 2);
			chk(offhook_done, 1'b0);
			wt(3);
			chk(offhook_done, 1'b1);
		end
		set_mode(2'h3);
		chk(line_mode_sel, 2'h1);
		summarize();
	end
endmodule
